/* cbx_core.sv */
// cbx_core: execution of late branches, bit operations and data transfers
//
// Notes on behaviour
// [RULE1] overflow-clear branch jumps pc+k+1, one/two cycles
// [RULE2] interrupt-bit branches likewise, flags untouched
// [RULE3] io bit set/clear, read-modify-write, two cycles
// [RULE4] shift left, zero in, flags, one cycle
// [RULE5] shift right, zero in, flags, one cycle
// [RULE6] rotate left through carry, one cycle
// [RULE7] rotate right through carry, one cycle
// [RULE8] arithmetic right shift keeps sign bit
// [RULE9] any single status flag set or cleared
// [RULE10] sign flag raise/drop touches sign only
// [RULE11] register bit copied into transfer flag
// [RULE12] transfer flag copied into register bit
// [RULE13] pointer loads, pre-dec or post-inc, two cycles
// [RULE14] pointer stores, pre-dec or post-inc, two cycles
// [RULE15] displaced load, pointer unchanged, two cycles
// [RULE16] displaced store, pointer unchanged, two cycles
// [RULE17] absolute load, two cycles
// [RULE18] absolute store, two cycles
// [RULE19] code read via third pointer, three cycles
// [RULE20] far code read uses page byte, three cycles
// [RULE21] code write stalls until memory completes
//
// The register offsets and the Wishbone slave port were chosen for this implementation.
`timescale 1ns/1ps
module cbx_core
	import cbx_pkg::*;
#(
	parameter int PC_W = 16
) (
	// clock and reset
	input logic clk_i,
	input logic rst_i,
	// decoded instruction issue
	input logic op_valid_i,
	input cbx_op_t op_i,
	output logic op_ready_o,
	output logic op_done_o,
	// data memory, read data valid while dm_re_o is high
	output logic [15:0] dm_addr_o,
	output logic [7:0] dm_wdata_o,
	output logic dm_we_o,
	output logic dm_re_o,
	input logic [7:0] dm_rdata_i,
	// i/o space, read data valid while io_re_o is high
	output logic [5:0] io_addr_o,
	output logic [7:0] io_wdata_o,
	output logic io_we_o,
	output logic io_re_o,
	input logic [7:0] io_rdata_i,
	// program memory
	output logic [23:0] pm_addr_o,
	output logic pm_re_o,
	input logic [7:0] pm_rdata_i,
	output logic [15:0] pm_wdata_o,
	output logic pm_we_o,
	input logic pm_done_i,
	// wishbone slave
	input logic wb_cyc_i,
	input logic wb_stb_i,
	input logic wb_we_i,
	input logic [7:0] wb_adr_i,
	input logic [3:0] wb_sel_i,
	input logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o
);
	// ------------------------------------------------------------
	// elaboration check
	// ------------------------------------------------------------
	if (PC_W < 8 || PC_W > 16) begin : g_pc_chk
		$error("PC_W must lie between 8 and 16");
	end

	typedef enum {
		ST_IDLE, ST_HOLD, ST_LOAD, ST_IO_MOD, ST_PM_WAIT, ST_PM_LOAD, ST_PM_WRITE
	} cbx_st_t;

	logic [7:0] rf_ff [32];
	logic [7:0] status_register_ff;
	logic [PC_W-1:0] pc_ff;
	logic [7:0] page_ff;
	logic run_ff;
	cbx_st_t st_ff;
	cbx_st_t nxt_st;
	logic [4:0] dst_ff;
	logic [2:0] iobit_ff;
	logic ioset_ff;
	logic [15:0] dm_addr_ff;
	logic [7:0] dm_wdata_ff;
	logic dm_we_ff;
	logic dm_re_ff;
	logic [5:0] io_addr_ff;
	logic [7:0] io_wdata_ff;
	logic io_we_ff;
	logic io_re_ff;
	logic [23:0] pm_addr_ff;
	logic pm_re_ff;
	logic [15:0] pm_wdata_ff;
	logic pm_we_ff;
	logic [7:0] sh_res;
	logic [3:0] sh_flg;
	logic [4:0] rf_idx;
	cbx_wr_t bus_wr;
	cbx_view_t view;

	// ------------------------------------------------------------
	// issue and operation classes
	// ------------------------------------------------------------
	wire cbx_opc_t opc = op_i.opc;
	assign op_ready_o = run_ff & (st_ff == ST_IDLE);
	wire take = op_valid_i & op_ready_o;
	wire is_br = (opc == OP_BR_NO_OVF) | (opc == OP_BR_IRQ_ON) | (opc == OP_BR_IRQ_OFF);
	wire is_io = (opc == OP_IO_SET) | (opc == OP_IO_CLR);
	wire is_shift = (opc == OP_SHL) | (opc == OP_SHR) | (opc == OP_ROTL) |
		(opc == OP_ROTR) | (opc == OP_ASHR);
	wire is_ind = (opc == OP_LD_IND) | (opc == OP_ST_IND);
	wire is_disp = (opc == OP_LD_DISP) | (opc == OP_ST_DISP);
	wire is_abs = (opc == OP_LD_ABS) | (opc == OP_ST_ABS);
	wire is_load = (opc == OP_LD_IND) | (opc == OP_LD_DISP) | (opc == OP_LD_ABS);
	wire is_store = (opc == OP_ST_IND) | (opc == OP_ST_DISP) | (opc == OP_ST_ABS);
	wire is_pm_rd = (opc == OP_PM_READ) | (opc == OP_PM_READ_FAR);
	wire is_pm_wr = (opc == OP_PM_WRITE);

	// ------------------------------------------------------------
	// branches: the offset is a signed word count
	// ------------------------------------------------------------
	wire br_cond = (opc == OP_BR_NO_OVF) ? ~status_register_ff[FLG_V] : // [RULE1]
		(opc == OP_BR_IRQ_ON) ? status_register_ff[FLG_I] : ~status_register_ff[FLG_I]; // [RULE2]
	wire br_go = take & is_br & br_cond;
	wire [PC_W-1:0] br_tgt = pc_ff + PC_W'($signed(op_i.k)) + PC_W'(1); // [RULE1] [RULE2]
	// absolute transfers carry a second instruction word
	wire [PC_W-1:0] pc_seq = pc_ff + (is_abs ? PC_W'(2) : PC_W'(1));

	// ------------------------------------------------------------
	// pointer arithmetic for the data space
	// ------------------------------------------------------------
	wire [4:0] pbase = (op_i.ptr == PTR_A) ? PTR_A_LO : (op_i.ptr == PTR_B) ? PTR_B_LO : PTR_C_LO;
	wire [4:0] phigh = {pbase[4:1], 1'b1};
	wire [15:0] pval = {rf_ff[phigh], rf_ff[pbase]};
	wire [15:0] pdec = pval - 16'h0001;
	wire [15:0] pinc = pval + 16'h0001;
	wire pre_dec = (op_i.pmode == PM_PRE_DEC);
	wire [15:0] ind_addr = pre_dec ? pdec : pval; // [RULE13] [RULE14]
	wire [15:0] disp_addr = pval + {10'h000, op_i.q}; // [RULE15] [RULE16]
	wire [15:0] dm_addr_c = is_abs ? op_i.addr : is_disp ? disp_addr : ind_addr; // [RULE17] [RULE18]
	// only the plain indirect forms move the pointer
	wire ptr_upd = take & is_ind & (op_i.pmode != PM_KEEP); // [RULE13] [RULE14]
	wire [15:0] ptr_new = pre_dec ? pdec : pinc;

	// ------------------------------------------------------------
	// program memory addressing
	// ------------------------------------------------------------
	wire [15:0] zval = {rf_ff[PTR_C_HI], rf_ff[PTR_C_LO]};
	wire [23:0] far_addr = {page_ff, zval}; // [RULE20]
	wire [23:0] far_inc = far_addr + 24'h000001; // [RULE20]
	wire [23:0] pm_addr_c = (opc == OP_PM_READ_FAR) ? far_addr : {8'h00, zval}; // [RULE19]
	wire pm_inc = take & is_pm_rd & (op_i.pmode == PM_POST_INC); // [RULE19]
	wire page_inc = pm_inc & (opc == OP_PM_READ_FAR); // [RULE20]

	// ------------------------------------------------------------
	// one-cycle register and flag operations
	// ------------------------------------------------------------
	wire [7:0] rd_val = rf_ff[op_i.rd];
	wire [7:0] ins_val = put_bit(rd_val, op_i.bit_sel, status_register_ff[FLG_T]); // [RULE12]
	wire [7:0] status_register_sh = {status_register_ff[7:4], sh_flg}; // {v,n,z,c} sit at bits 3..0
	wire [7:0] status_register_tcap = put_bit(status_register_ff, 3'(FLG_T), rd_val[op_i.bit_sel]); // [RULE11]
	// a flag op names the flag by its bit; the sign flag is bit FLG_S
	wire [7:0] status_register_op = is_shift ? status_register_sh :
		(opc == OP_FLAG_SET) ? put_bit(status_register_ff, op_i.bit_sel, 1'b1) : // [RULE9] [RULE10]
		(opc == OP_FLAG_CLR) ? put_bit(status_register_ff, op_i.bit_sel, 1'b0) : // [RULE9] [RULE10]
		(opc == OP_T_CAPTURE) ? status_register_tcap : status_register_ff;
	wire status_register_upd = take & (is_shift | (opc == OP_FLAG_SET) | (opc == OP_FLAG_CLR) |
		(opc == OP_T_CAPTURE));
	// t-insert writes the register only, so the flags stay as they were
	wire rf1_we = take & (is_shift | (opc == OP_T_INSERT)); // [RULE12]
	wire [7:0] rf1_dat = is_shift ? sh_res : ins_val;
	// late writes return memory data in the last cycle of a load
	wire rf2_we = (st_ff == ST_LOAD) | (st_ff == ST_PM_LOAD); // [RULE13] [RULE19]
	wire [7:0] rf2_dat = (st_ff == ST_LOAD) ? dm_rdata_i : pm_rdata_i;
	wire one_cyc = ~(br_go | is_io | is_load | is_store | is_pm_rd | is_pm_wr);

	// ------------------------------------------------------------
	// helper units
	// ------------------------------------------------------------
	cbx_shift u_shift (
		.opc_i(opc),
		.val_i(rd_val),
		.carry_i(status_register_ff[FLG_C]),
		.res_o(sh_res),
		.flg_o(sh_flg)
	);

	assign view.run = run_ff;
	assign view.busy = (st_ff != ST_IDLE);
	assign view.pm_wait = (st_ff == ST_PM_WRITE);
	assign view.status_register = status_register_ff;
	assign view.pc = 16'(pc_ff);
	assign view.page = page_ff;
	assign view.rf_data = rf_ff[rf_idx];

	cbx_wb_regs u_regs (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i),
		.wb_adr_i(wb_adr_i),
		.wb_sel_i(wb_sel_i),
		.wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o),
		.view_i(view),
		.rf_idx_o(rf_idx),
		.wr_o(bus_wr)
	);

	// ------------------------------------------------------------
	// register file: core writes come last so they beat the bus
	// ------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			for (int i = 0; i < 32; i++) begin
				rf_ff[i] <= 8'h00;
			end
		end else begin
			if (bus_wr.rf) begin
				rf_ff[bus_wr.idx] <= bus_wr.data[7:0];
			end
			if (ptr_upd) begin
				rf_ff[phigh] <= ptr_new[15:8]; // [RULE13] [RULE14]
				rf_ff[pbase] <= ptr_new[7:0];
			end
			if (pm_inc) begin
				rf_ff[PTR_C_HI] <= far_inc[15:8]; // [RULE19] [RULE20]
				rf_ff[PTR_C_LO] <= far_inc[7:0];
			end
			if (rf1_we) begin
				rf_ff[op_i.rd] <= rf1_dat; // [RULE4] [RULE12]
			end
			if (rf2_we) begin
				rf_ff[dst_ff] <= rf2_dat; // [RULE13] [RULE15] [RULE17] [RULE19]
			end
		end
	end

	// status, program counter, page byte and run control
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			status_register_ff <= STATUS_REGISTER_RST;
			pc_ff <= '0;
			page_ff <= PAGE_RST;
			run_ff <= RUN_RST;
		end else begin
			if (bus_wr.status_register) status_register_ff <= bus_wr.data[7:0];
			if (status_register_upd) status_register_ff <= status_register_op; // [RULE9]
			if (bus_wr.pc) pc_ff <= bus_wr.data[PC_W-1:0];
			if (take) pc_ff <= br_go ? br_tgt : pc_seq; // [RULE1] [RULE2]
			if (bus_wr.page) page_ff <= bus_wr.data[7:0];
			if (page_inc) page_ff <= far_inc[23:16]; // [RULE20]
			if (bus_wr.ctrl) run_ff <= bus_wr.data[0];
		end
	end

	// ------------------------------------------------------------
	// sequencing of multi-cycle operations
	// ------------------------------------------------------------
	always_comb begin
		nxt_st = st_ff;
		unique case (st_ff)
			ST_IDLE: begin
				if (take) begin
					if (br_go | is_store) nxt_st = ST_HOLD; // [RULE1] [RULE14] [RULE16] [RULE18]
					else if (is_load) nxt_st = ST_LOAD; // [RULE13] [RULE15] [RULE17]
					else if (is_io) nxt_st = ST_IO_MOD; // [RULE3]
					else if (is_pm_rd) nxt_st = ST_PM_WAIT; // [RULE19]
					else if (is_pm_wr) nxt_st = ST_PM_WRITE; // [RULE21]
				end
			end
			ST_PM_WAIT: nxt_st = ST_PM_LOAD;
			ST_PM_WRITE: begin
				if (pm_done_i) nxt_st = ST_IDLE; // [RULE21]
			end
			ST_HOLD, ST_LOAD, ST_IO_MOD, ST_PM_LOAD: nxt_st = ST_IDLE;
		endcase
	end

	assign op_done_o = (take & one_cyc) | (st_ff == ST_HOLD) | (st_ff == ST_LOAD) |
		(st_ff == ST_IO_MOD) | (st_ff == ST_PM_LOAD) | ((st_ff == ST_PM_WRITE) & pm_done_i);

	// memory strobes are one-cycle pulses, except the code write request
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_ff <= ST_IDLE;
			{dm_re_ff, dm_we_ff, io_re_ff, io_we_ff, pm_re_ff, pm_we_ff} <= 6'h00;
			{dst_ff, iobit_ff, ioset_ff} <= 9'h000;
			{dm_addr_ff, dm_wdata_ff, io_addr_ff, io_wdata_ff} <= 38'h0000000000;
			{pm_addr_ff, pm_wdata_ff} <= 40'h0000000000;
		end else begin
			st_ff <= nxt_st;
			dm_re_ff <= take & is_load;
			dm_we_ff <= take & is_store; // [RULE14] [RULE16] [RULE18]
			io_re_ff <= take & is_io;
			io_we_ff <= (st_ff == ST_IO_MOD); // [RULE3]
			pm_re_ff <= take & is_pm_rd;
			if (take) dst_ff <= op_i.rd;
			if (take & (is_load | is_store)) begin
				dm_addr_ff <= dm_addr_c;
				dm_wdata_ff <= rd_val;
			end
			if (take & is_io) begin
				io_addr_ff <= op_i.io_addr;
				iobit_ff <= op_i.bit_sel;
				ioset_ff <= (opc == OP_IO_SET);
			end
			// other bits of the i/o register pass through unchanged
			if (st_ff == ST_IO_MOD) io_wdata_ff <= put_bit(io_rdata_i, iobit_ff, ioset_ff); // [RULE3]
			if (take & (is_pm_rd | is_pm_wr)) pm_addr_ff <= pm_addr_c;
			if (take & is_pm_wr) begin
				pm_wdata_ff <= {rf_ff[WORK_HI_IDX], rf_ff[WORK_LO_IDX]}; // [RULE21]
				pm_we_ff <= 1'b1;
			end else if (pm_done_i) begin
				pm_we_ff <= 1'b0;
			end
		end
	end

	assign dm_addr_o = dm_addr_ff;
	assign dm_wdata_o = dm_wdata_ff;
	assign dm_we_o = dm_we_ff;
	assign dm_re_o = dm_re_ff;
	assign io_addr_o = io_addr_ff;
	assign io_wdata_o = io_wdata_ff;
	assign io_we_o = io_we_ff;
	assign io_re_o = io_re_ff;
	assign pm_addr_o = pm_addr_ff;
	assign pm_re_o = pm_re_ff;
	assign pm_wdata_o = pm_wdata_ff;
	assign pm_we_o = pm_we_ff;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	sequence s_io_rmw;
		io_re_o ##1 (io_we_o && $stable(io_addr_o));
	endsequence
	sequence s_code_read;
		(st_ff == ST_PM_WAIT) && pm_re_o ##1 (st_ff == ST_PM_LOAD) ##1 (st_ff == ST_IDLE);
	endsequence

	a_branch_no_ovf: assert property (take && opc == OP_BR_NO_OVF && !status_register_ff[FLG_V] // [RULE1]
		|=> pc_ff == $past(br_tgt) && st_ff == ST_HOLD ##1 st_ff == ST_IDLE)
		else $error("overflow-clear branch target or timing wrong");
	a_branch_irq_skip: assert property (take && is_br && opc != OP_BR_NO_OVF && !br_cond // [RULE2]
		|=> pc_ff == $past(pc_seq) && st_ff == ST_IDLE)
		else $error("interrupt branch not taken took wrong path");
	a_io_rmw_seq: assert property (take && is_io |=> s_io_rmw) // [RULE3]
		else $error("io bit update sequence broken");
	a_shl_value: assert property (take && opc == OP_SHL // [RULE4]
		|=> rf_ff[$past(op_i.rd)] == {$past(rd_val[6:0]), 1'b0} && status_register_ff[FLG_C] == $past(rd_val[7]))
		else $error("left shift result or carry wrong");
	a_rotr_value: assert property (take && opc == OP_ROTR // [RULE7]
		|=> rf_ff[$past(op_i.rd)][7] == $past(status_register_ff[FLG_C]) && status_register_ff[FLG_C] == $past(rd_val[0]))
		else $error("right rotate carry path wrong");
	a_shift_flags: assert property (take && is_shift // [RULE8]
		|=> status_register_ff[FLG_V] == (status_register_ff[FLG_N] ^ status_register_ff[FLG_C]) && status_register_ff[7:4] == $past(status_register_ff[7:4]))
		else $error("shift flag update wrong");
	a_flag_single: assert property (take && opc == OP_FLAG_SET // [RULE9]
		|=> status_register_ff == ($past(status_register_ff) | (8'h01 << $past(op_i.bit_sel))))
		else $error("flag set touched other flags");
	a_t_capture: assert property (take && opc == OP_T_CAPTURE // [RULE11]
		|=> status_register_ff[FLG_T] == $past(rd_val[op_i.bit_sel]))
		else $error("transfer flag capture wrong");
	a_load_two: assert property (take && is_load |=> dm_re_o && !op_ready_o ##1 st_ff == ST_IDLE) // [RULE13]
		else $error("data load not two cycles");
	a_disp_addr: assert property (take && is_disp // [RULE15]
		|=> dm_addr_o == $past(disp_addr) && st_ff != ST_IDLE ##1 st_ff == ST_IDLE)
		else $error("displaced access address or timing wrong");
	a_code_read: assert property (take && is_pm_rd |=> s_code_read) // [RULE19]
		else $error("code read not three cycles");
	a_far_inc: assert property (take && opc == OP_PM_READ_FAR && op_i.pmode == PM_POST_INC // [RULE20]
		|=> far_addr == $past(far_inc))
		else $error("far code pointer increment wrong");
	a_code_write_stall: assert property (st_ff == ST_PM_WRITE && !pm_done_i // [RULE21]
		|=> pm_we_o && !op_ready_o)
		else $error("code write released before completion");
endmodule : cbx_core

/* cbx_pkg.sv */
// cbx_pkg: shared constants, types and helpers of the bit and transfer execution core
package cbx_pkg;
	// ------------------------------------------------------------
	// status register bit positions
	// ------------------------------------------------------------
	localparam int FLG_C = 0;
	localparam int FLG_Z = 1;
	localparam int FLG_N = 2;
	localparam int FLG_V = 3;
	localparam int FLG_S = 4;
	localparam int FLG_H = 5;
	localparam int FLG_T = 6;
	localparam int FLG_I = 7;

	// ------------------------------------------------------------
	// register file indices of the work pair and pointer pairs
	// ------------------------------------------------------------
	localparam logic [4:0] WORK_LO_IDX = 5'h00;
	localparam logic [4:0] WORK_HI_IDX = 5'h01;
	localparam logic [4:0] PTR_A_LO = 5'h1A;
	localparam logic [4:0] PTR_B_LO = 5'h1C;
	localparam logic [4:0] PTR_C_LO = 5'h1E;
	localparam logic [4:0] PTR_C_HI = 5'h1F;

	// ------------------------------------------------------------
	// bus register map (byte offsets) and reset values
	// ------------------------------------------------------------
	localparam logic [7:0] ADR_CTRL = 8'h00;
	localparam logic [7:0] ADR_STATUS_REGISTER = 8'h04;
	localparam logic [7:0] ADR_PC = 8'h08;
	localparam logic [7:0] ADR_PAGE = 8'h0C;
	localparam logic [7:0] ADR_STAT = 8'h10;
	localparam int RF_WIN_BIT = 7;
	localparam logic [7:0] STATUS_REGISTER_RST = 8'h00;
	localparam logic [7:0] PAGE_RST = 8'h00;
	localparam logic RUN_RST = 1'b0;

	// ------------------------------------------------------------
	// operations, pointer choice and pointer update mode
	// ------------------------------------------------------------
	typedef enum logic [4:0] {
		OP_BR_NO_OVF, OP_BR_IRQ_ON, OP_BR_IRQ_OFF, OP_IO_SET, OP_IO_CLR,
		OP_SHL, OP_SHR, OP_ROTL, OP_ROTR, OP_ASHR, OP_FLAG_SET, OP_FLAG_CLR,
		OP_T_CAPTURE, OP_T_INSERT, OP_LD_IND, OP_ST_IND, OP_LD_DISP, OP_ST_DISP,
		OP_LD_ABS, OP_ST_ABS, OP_PM_READ, OP_PM_READ_FAR, OP_PM_WRITE
	} cbx_opc_t;
	typedef enum logic [1:0] {PTR_A, PTR_B, PTR_C} cbx_ptr_t;
	typedef enum logic [1:0] {PM_KEEP, PM_POST_INC, PM_PRE_DEC} cbx_pmode_t;

	// one decoded instruction as handed over by the decoder
	typedef struct packed {
		cbx_opc_t opc;
		logic [4:0] rd;
		logic [2:0] bit_sel;
		logic [6:0] k;
		logic [5:0] q;
		logic [15:0] addr;
		logic [5:0] io_addr;
		cbx_ptr_t ptr;
		cbx_pmode_t pmode;
	} cbx_op_t;

	// bus writes decoded per target
	typedef struct packed {
		logic ctrl;
		logic status_register;
		logic pc;
		logic page;
		logic rf;
		logic [4:0] idx;
		logic [31:0] data;
	} cbx_wr_t;

	// core state shown to the bus
	typedef struct packed {
		logic run;
		logic busy;
		logic pm_wait;
		logic [7:0] status_register;
		logic [15:0] pc;
		logic [7:0] page;
		logic [7:0] rf_data;
	} cbx_view_t;

	// replace one bit of a byte
	function automatic logic [7:0] put_bit(input logic [7:0] v, input logic [2:0] i,
		input logic b);
		logic [7:0] r;
		r = v;
		r[i] = b;
		return r;
	endfunction : put_bit
endpackage : cbx_pkg

/* cbx_shift.sv */
// cbx_shift: combinational shift and rotate unit with its flag results
`timescale 1ns/1ps
module cbx_shift
	import cbx_pkg::*;
(
	// operation and operand
	input cbx_opc_t opc_i,
	input logic [7:0] val_i,
	input logic carry_i,
	// result and flags, packed as {v, n, z, c}
	output logic [7:0] res_o,
	output logic [3:0] flg_o
);
	// ------------------------------------------------------------
	// result selection
	// ------------------------------------------------------------
	wire [7:0] shl = {val_i[6:0], 1'b0}; // [RULE4]
	wire [7:0] shr = {1'b0, val_i[7:1]}; // [RULE5]
	wire [7:0] rotl = {val_i[6:0], carry_i}; // [RULE6]
	wire [7:0] rotr = {carry_i, val_i[7:1]}; // [RULE7]
	wire [7:0] ashr = {val_i[7], val_i[7:1]}; // [RULE8]
	wire left = (opc_i == OP_SHL) | (opc_i == OP_ROTL);
	assign res_o = (opc_i == OP_SHL) ? shl :
		(opc_i == OP_SHR) ? shr :
		(opc_i == OP_ROTL) ? rotl :
		(opc_i == OP_ROTR) ? rotr :
		(opc_i == OP_ASHR) ? ashr : val_i;

	// ------------------------------------------------------------
	// flags: the bit pushed out is the carry, overflow is n xor c
	// ------------------------------------------------------------
	wire c_out = left ? val_i[7] : val_i[0];
	wire n_out = res_o[7];
	wire z_out = (res_o == 8'h00);
	assign flg_o = {n_out ^ c_out, n_out, z_out, c_out}; // [RULE4] [RULE5] [RULE6] [RULE7] [RULE8]
endmodule : cbx_shift

/* cbx_wb_regs.sv */
// cbx_wb_regs: classic Wishbone slave holding the register map of the core
`timescale 1ns/1ps
module cbx_wb_regs
	import cbx_pkg::*;
(
	// clock and reset
	input logic clk_i,
	input logic rst_i,
	// wishbone slave
	input logic wb_cyc_i,
	input logic wb_stb_i,
	input logic wb_we_i,
	input logic [7:0] wb_adr_i,
	input logic [3:0] wb_sel_i,
	input logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// core side
	input cbx_view_t view_i,
	output logic [4:0] rf_idx_o,
	output cbx_wr_t wr_o
);
	logic ack_ff;
	logic [31:0] dat_ff;

	// merge written byte lanes into the present value
	function automatic logic [31:0] lane_merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				r[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return r;
	endfunction : lane_merge

	// ------------------------------------------------------------
	// address decode; unmapped offsets read zero and ignore writes
	// ------------------------------------------------------------
	wire req = wb_cyc_i & wb_stb_i;
	wire hit_rf = wb_adr_i[RF_WIN_BIT];
	wire [31:0] rd_val = hit_rf ? {24'h000000, view_i.rf_data} :
		(wb_adr_i == ADR_CTRL) ? {31'h00000000, view_i.run} :
		(wb_adr_i == ADR_STATUS_REGISTER) ? {24'h000000, view_i.status_register} :
		(wb_adr_i == ADR_PC) ? {16'h0000, view_i.pc} :
		(wb_adr_i == ADR_PAGE) ? {24'h000000, view_i.page} :
		(wb_adr_i == ADR_STAT) ? {30'h00000000, view_i.pm_wait, view_i.busy} : 32'h00000000;
	// writes land on the edge at which the master sees ack
	wire wr_go = req & wb_we_i & ack_ff;
	assign rf_idx_o = wb_adr_i[6:2];
	assign wr_o.idx = wb_adr_i[6:2];
	assign wr_o.data = lane_merge(rd_val, wb_dat_i, wb_sel_i);
	assign wr_o.ctrl = wr_go & (wb_adr_i == ADR_CTRL);
	assign wr_o.status_register = wr_go & (wb_adr_i == ADR_STATUS_REGISTER);
	assign wr_o.pc = wr_go & (wb_adr_i == ADR_PC);
	assign wr_o.page = wr_go & (wb_adr_i == ADR_PAGE);
	assign wr_o.rf = wr_go & hit_rf;
	assign wb_ack_o = ack_ff;
	assign wb_dat_o = dat_ff;

	// one wait state: ack rises the cycle after the request, for one cycle
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_ff <= 1'b0;
			dat_ff <= 32'h00000000;
		end else begin
			ack_ff <= req & ~ack_ff;
			if (req & ~ack_ff) begin
				dat_ff <= rd_val;
			end
		end
	end
endmodule : cbx_wb_regs

/* cbx_mem_model.sv */
// cbx_mem_model: data memory, i/o space and program memory beside the core
`timescale 1ns/1ps
module cbx_mem_model (
	// clock
	input wire logic clk_i,
	// data memory
	input wire logic [15:0] dm_addr_i,
	input wire logic [7:0] dm_wdata_i,
	input wire logic dm_we_i,
	input wire logic dm_re_i,
	output logic [7:0] dm_rdata_o,
	// i/o space
	input wire logic [5:0] io_addr_i,
	input wire logic [7:0] io_wdata_i,
	input wire logic io_we_i,
	input wire logic io_re_i,
	output logic [7:0] io_rdata_o,
	// program memory, one cycle read latency
	input wire logic [23:0] pm_addr_i,
	input wire logic pm_re_i,
	output logic [7:0] pm_rdata_o
);
	logic [7:0] dm_ff [256];
	logic [7:0] io_ff [64];
	logic pv_ff;
	logic [7:0] pa_ff;
	// known fill patterns so the bench can predict every byte
	initial for (int i = 0; i < 256; i++) begin
		dm_ff[i] = i[7:0] ^ 8'h5A;
		io_ff[i[5:0]] = 8'h00;
	end
	// outside a read strobe the data and i/o buses show the inverse, the program bus the inverted address byte
	assign dm_rdata_o = dm_re_i ? dm_ff[dm_addr_i[7:0]] : ~dm_ff[dm_addr_i[7:0]];
	assign io_rdata_o = io_re_i ? io_ff[io_addr_i] : ~io_ff[io_addr_i];
	assign pm_rdata_o = pv_ff ? (pa_ff ^ 8'hC3) : ~pa_ff;
	// writes land at the edge; program reads answer one cycle late
	always @(posedge clk_i) begin
		pv_ff <= pm_re_i;
		pa_ff <= pm_addr_i[7:0];
		if (dm_we_i) dm_ff[dm_addr_i[7:0]] <= dm_wdata_i;
		if (io_we_i) io_ff[io_addr_i] <= io_wdata_i;
	end
endmodule : cbx_mem_model

/* tb.sv */
// tb: self-checking bench of the execution core
`timescale 1ns/1ps
module tb;
	import cbx_pkg::*;
	logic clk_i, rst_i, op_valid_i, op_ready_o, op_done_o, dm_we_o, dm_re_o, io_we_o, io_re_o;
	logic pm_re_o, pm_we_o, pm_done_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
	logic [15:0] dm_addr_o, pm_wdata_o;
	logic [7:0] dm_wdata_o, dm_rdata_i, io_wdata_o, io_rdata_i, pm_rdata_i, wb_adr_i;
	logic [5:0] io_addr_o;
	logic [23:0] pm_addr_o;
	logic [3:0] wb_sel_i;
	logic [31:0] wb_dat_i, wb_dat_o, rd_q;
	cbx_op_t op_i;
	int errors, checks_done;
	cbx_core i_dut (.*);
	cbx_mem_model i_mem (.clk_i(clk_i), .dm_addr_i(dm_addr_o), .dm_wdata_i(dm_wdata_o),
		.dm_we_i(dm_we_o), .dm_re_i(dm_re_o), .dm_rdata_o(dm_rdata_i), .io_addr_i(io_addr_o),
		.io_wdata_i(io_wdata_o), .io_we_i(io_we_o), .io_re_i(io_re_o), .io_rdata_o(io_rdata_i),
		.pm_addr_i(pm_addr_o), .pm_re_i(pm_re_o), .pm_rdata_o(pm_rdata_i));
	initial begin
		clk_i = 1'b0;
		forever #20 clk_i = ~clk_i;
	end
	task automatic ck(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : ck
	// one classic cycle, held until ack is sampled
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		wb_cyc_i <= 1'b1; wb_stb_i <= 1'b1; wb_we_i <= w; wb_adr_i <= a; wb_dat_i <= d;
		do @(posedge clk_i); while (wb_ack_o !== 1'b1);
		rd_q = wb_dat_o;
		wb_cyc_i <= 1'b0; wb_stb_i <= 1'b0;
		@(posedge clk_i);
	endtask : wb
	task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
		wb(1'b0, a, 32'h0);
		ck(rd_q, exp);
	endtask : rchk
	// issue one instruction and count cycles until the core is ready again
	task automatic iss(input cbx_opc_t c, input logic [4:0] r, input logic [2:0] b,
		input logic [6:0] k, input logic [5:0] q, input cbx_ptr_t p, input cbx_pmode_t m,
		input int n);
		cbx_op_t o;
		int cy;
		int dn;
		o = '0; o.opc = c; o.rd = r; o.bit_sel = b; o.k = k; o.q = q;
		o.addr = {10'h000, q}; o.io_addr = q; o.ptr = p; o.pmode = m;
		cy = 0; op_valid_i <= 1'b1; op_i <= o;
		do @(posedge clk_i); while (op_ready_o !== 1'b1);
		dn = (op_done_o === 1'b1);
		op_valid_i <= 1'b0;
		do begin @(posedge clk_i); cy++; dn += (op_done_o === 1'b1); end while (op_ready_o !== 1'b1 && cy < 20);
		ck(cy, n);
		ck(dn, 1);
	endtask : iss
	task automatic final_report();
		if (errors == 0 && checks_done > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : final_report
	// watchdog: the whole sequence needs well under a thousand cycles
	initial begin
		repeat (5000) @(posedge clk_i);
		errors++;
		final_report();
	end
	initial begin
		errors = 0; checks_done = 0; rst_i = 1'b1; op_valid_i = 1'b0; op_i = '0;
		pm_done_i = 1'b0; wb_cyc_i = 1'b0; wb_stb_i = 1'b0; wb_we_i = 1'b0;
		wb_adr_i = 8'h00; wb_sel_i = 4'hF; wb_dat_i = 32'h0;
		repeat (10) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		wb(1'b1, ADR_CTRL, 32'h1); wb(1'b1, 8'hC0, 32'h81);
		wb(1'b1, 8'hE8, 32'h10); wb(1'b1, 8'hF8, 32'h20);
		iss(OP_SHL, 5'h10, 3'h0, 7'h00, 6'h00, PTR_A, PM_KEEP, 1);
		rchk(8'hC0, 32'h02);
		rchk(ADR_STATUS_REGISTER, 32'h09);
		iss(OP_BR_NO_OVF, 5'h00, 3'h0, 7'h03, 6'h00, PTR_A, PM_KEEP, 1);
		wb(1'b1, ADR_STATUS_REGISTER, 32'h0);
		iss(OP_BR_NO_OVF, 5'h00, 3'h0, 7'h03, 6'h00, PTR_A, PM_KEEP, 2);
		rchk(ADR_PC, 32'h6);
		iss(OP_BR_IRQ_OFF, 5'h00, 3'h0, 7'h01, 6'h00, PTR_A, PM_KEEP, 2);
		rchk(ADR_PC, 32'h8);
		iss(OP_FLAG_SET, 5'h00, 3'h4, 7'h00, 6'h00, PTR_A, PM_KEEP, 1);
		rchk(ADR_STATUS_REGISTER, 32'h10);
		iss(OP_LD_IND, 5'h05, 3'h0, 7'h00, 6'h00, PTR_A, PM_POST_INC, 2);
		rchk(8'h94, 32'h4A);
		rchk(8'hE8, 32'h11);
		iss(OP_ST_DISP, 5'h10, 3'h0, 7'h00, 6'h03, PTR_C, PM_KEEP, 2);
		iss(OP_LD_ABS, 5'h06, 3'h0, 7'h00, 6'h23, PTR_A, PM_KEEP, 2);
		rchk(8'h98, 32'h02);
		rchk(8'hF8, 32'h20);
		iss(OP_PM_READ, 5'h07, 3'h0, 7'h00, 6'h00, PTR_C, PM_POST_INC, 3);
		rchk(8'h9C, 32'hE3);
		rchk(8'hF8, 32'h21);
		iss(OP_IO_SET, 5'h00, 3'h3, 7'h00, 6'h05, PTR_A, PM_KEEP, 2);
		rchk(ADR_STATUS_REGISTER, 32'h10);
		ck({24'h0, i_mem.io_ff[5]}, 32'h08);
		iss(OP_BR_IRQ_ON, 5'h00, 3'h0, 7'h05, 6'h00, PTR_A, PM_KEEP, 1);
		rchk(ADR_PC, 32'h10);
		iss(OP_ROTR, 5'h07, 3'h0, 7'h00, 6'h00, PTR_A, PM_KEEP, 1);
		rchk(8'h9C, 32'h71);
		iss(OP_T_CAPTURE, 5'h07, 3'h4, 7'h00, 6'h00, PTR_A, PM_KEEP, 1);
		rchk(ADR_STATUS_REGISTER, 32'h59);
		iss(OP_T_INSERT, 5'h10, 3'h7, 7'h00, 6'h00, PTR_A, PM_KEEP, 1);
		rchk(8'hC0, 32'h82);
		final_report();
	end
endmodule : tb
